// [core/epic_ctrl.sv]
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module epic_ctrl
   import epic_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic samp_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic nmi_pin,
   input wire logic [29:0] ext_irq_pin,
   output logic nmi_irq,
   output logic [29:0] line_irq,
   output logic wake_out
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [NL-1:0] mask_q;
   logic [NL-1:0] pend_q;
   logic [NL-1:0] pend_d;
   logic [NL-1:0] active_q;
   logic [NL-1:0] active_d;
   logic [NL-1:0] mode_q;
   logic [NL-1:0] edge_q;
   logic [NL-1:0] lvl_q;
   logic [NL-1:0] filt_q;
   logic [NL-1:0] clockless_path_sel_q;
   logic [31:0] test_q;
   logic [NL-1:0] irq_q;
   logic wake_q;
   logic ready_q;
   logic resp_q;
   logic [31:0] rdata_q;
   logic wr_q;
   logic [11:0] addr_q;
   logic addr_ph;
   logic [NL-1:0] wbits;
   logic [NL-1:0] trig;

   epic_line_if lines ();

   assign lines.mode = mode_q;
   assign lines.edg = edge_q;
   assign lines.lvl = lvl_q;
   assign lines.filt = filt_q;
   assign lines.asyn = clockless_path_sel_q;
   assign lines.act = active_q;
   assign lines.pin = {ext_irq_pin, nmi_pin};
   assign trig = lines.trig;

   epic_line_det u_det (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .samp_en(samp_en),
      .lines(lines)
   );

   // ---------------------------------------------------------------
   // Bus slave
   // ---------------------------------------------------------------
   function automatic logic wr_hit(input logic w, input logic [11:0] a, input logic [11:0] off);
      wr_hit = w && (a == off);
   endfunction

   function automatic logic [31:0] rd_mux(input logic [11:0] a);
      case (a)
         OFF_MASK_STATE: rd_mux = {1'b0, mask_q};
         OFF_PEND_STATUS: rd_mux = {1'b0, pend_q};
         OFF_TRIG_TYPE: rd_mux = {1'b0, mode_q};
         OFF_EDGE_POL: rd_mux = {1'b0, edge_q};
         OFF_LEVEL_POL: rd_mux = {1'b0, lvl_q};
         OFF_FILTER_SEL: rd_mux = {1'b0, filt_q};
         OFF_TEST: rd_mux = test_q;
         OFF_CLOCKLESS_PATH_SEL_SEL: rd_mux = {1'b0, clockless_path_sel_q};
         OFF_ACTIVE_STATE: rd_mux = {1'b0, active_q};
         OFF_REVISION: rd_mux = REVISION_VAL;
         default: rd_mux = WORD_RST;
      endcase
   endfunction

   assign addr_ph = hsel && hready && (htrans == HTRANS_NONSEQ);
   // Bit 31 is dropped; zeros written to set/clear bits do nothing
   assign wbits = hwdata[NL-1:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         addr_q <= 12'h000;
         rdata_q <= WORD_RST;
         ready_q <= 1'b1;
         resp_q <= HRESP_OKAY;
      end else if (ce) begin
         ready_q <= 1'b1;
         resp_q <= HRESP_OKAY;
         wr_q <= addr_ph && hwrite;
         if (addr_ph) begin
            addr_q <= haddr[11:0];
            // Read data latched here so hrdata comes from a flop
            rdata_q <= hwrite ? WORD_RST : rd_mux(haddr[11:0]);
         end
      end
   end

   assign hreadyout = ready_q;
   assign hresp = resp_q;
   assign hrdata = rdata_q;

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= LINE_RST;
         edge_q <= LINE_RST;
         lvl_q <= LINE_RST;
         filt_q <= LINE_RST;
         clockless_path_sel_q <= LINE_RST;
         test_q <= WORD_RST;
      end else if (ce) begin
         if (wr_hit(wr_q, addr_q, OFF_TRIG_TYPE)) mode_q <= wbits;
         if (wr_hit(wr_q, addr_q, OFF_EDGE_POL)) edge_q <= wbits;
         if (wr_hit(wr_q, addr_q, OFF_LEVEL_POL)) lvl_q <= wbits;
         if (wr_hit(wr_q, addr_q, OFF_FILTER_SEL)) filt_q <= wbits;
         if (wr_hit(wr_q, addr_q, OFF_CLOCKLESS_PATH_SEL_SEL)) clockless_path_sel_q <= wbits;
         if (wr_hit(wr_q, addr_q, OFF_TEST)) test_q <= hwdata;
      end
   end

   // ---------------------------------------------------------------
   // Mask, activation and pending
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_q <= LINE_RST;
      end else if (ce) begin
         if (wr_hit(wr_q, addr_q, OFF_MASK_SET)) mask_q <= mask_q | wbits;
         if (wr_hit(wr_q, addr_q, OFF_MASK_CLEAR)) mask_q <= mask_q & ~wbits;
      end
   end

   always_comb begin
      active_d = active_q;
      if (wr_hit(wr_q, addr_q, OFF_ACTIVATE)) active_d = active_d | wbits;
      if (wr_hit(wr_q, addr_q, OFF_DEACTIVATE)) active_d = active_d & ~wbits;
      pend_d = pend_q;
      if (wr_hit(wr_q, addr_q, OFF_PEND_CLEAR)) pend_d = pend_d & ~wbits;
      // A new trigger beats a clear; deactivation beats both
      pend_d = (pend_d | trig) & active_d;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         active_q <= LINE_RST;
         pend_q <= LINE_RST;
      end else if (ce) begin
         active_q <= active_d;
         pend_q <= pend_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Debug halt has no input here; ce low is what freezes the detector
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_q <= LINE_RST;
         wake_q <= 1'b0;
      end else if (ce) begin
         irq_q <= pend_q & mask_q;
         // Registered wake: the clockless_path_sel level reaches it without a sample tick
         wake_q <= |lines.wake;
      end
   end

   assign nmi_irq = irq_q[NMI_BIT];
   assign line_irq = irq_q[NL-1:1];
   assign wake_out = wake_q;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic rd_ph;
   assign rd_ph = ce && addr_ph && !hwrite;

   pend_inactive_a: assert property (@(posedge hclk) disable iff (!hresetn) (pend_q & ~active_q) == LINE_RST)
      else $error("pending set on inactive line");

   irq_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ce |=> irq_q == $past(pend_q & mask_q))
      else $error("request not pending and mask");

   trig_sets_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && (|trig) && !wr_hit(wr_q, addr_q, OFF_DEACTIVATE)) |=> (pend_q & $past(trig)) == $past(trig))
      else $error("trigger did not set pending");

   clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && wr_hit(wr_q, addr_q, OFF_PEND_CLEAR)) |=> (pend_q & $past(wbits & ~trig)) == LINE_RST)
      else $error("pending clear ignored");

   deact_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && wr_hit(wr_q, addr_q, OFF_DEACTIVATE)) |=> ((active_q | pend_q) & $past(wbits)) == LINE_RST)
      else $error("deactivate left line active");

   mask_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && wr_hit(wr_q, addr_q, OFF_MASK_SET)) |=> (mask_q & $past(wbits)) == $past(wbits))
      else $error("mask set ignored");

   wake_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
      wake_q |-> $past(|active_q))
      else $error("wake without active line");

   rsvd_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(rd_ph && haddr[11:0] != OFF_TEST && haddr[11:0] != OFF_REVISION) |-> !hrdata[31])
      else $error("bit 31 read nonzero");

   mask_clr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && wr_hit(wr_q, addr_q, OFF_MASK_CLEAR)) |=> (mask_q & $past(wbits)) == LINE_RST)
      else $error("mask clear ignored");

   act_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && wr_hit(wr_q, addr_q, OFF_ACTIVATE)) |=> (active_q & $past(wbits)) == $past(wbits))
      else $error("activate ignored");

   mode_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && wr_hit(wr_q, addr_q, OFF_TRIG_TYPE)) |=> mode_q == $past(wbits))
      else $error("trigger type write lost");

   edge_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && wr_hit(wr_q, addr_q, OFF_EDGE_POL)) |=> edge_q == $past(wbits))
      else $error("edge polarity write lost");

   lvl_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && wr_hit(wr_q, addr_q, OFF_LEVEL_POL)) |=> lvl_q == $past(wbits))
      else $error("level polarity write lost");

   filt_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && wr_hit(wr_q, addr_q, OFF_FILTER_SEL)) |=> filt_q == $past(wbits))
      else $error("filter select write lost");

   clockless_path_sel_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && wr_hit(wr_q, addr_q, OFF_CLOCKLESS_PATH_SEL_SEL)) |=> clockless_path_sel_q == $past(wbits))
      else $error("clockless_path_sel select write lost");

   test_wr_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && wr_hit(wr_q, addr_q, OFF_TEST)) |=> test_q == $past(hwdata))
      else $error("test word write lost");

   pend_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && !wr_hit(wr_q, addr_q, OFF_PEND_CLEAR) && !wr_hit(wr_q, addr_q, OFF_DEACTIVATE))
      |=> (pend_q & $past(pend_q)) == $past(pend_q))
      else $error("pending dropped without clear");

   no_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && !samp_en && !wr_hit(wr_q, addr_q, OFF_PEND_CLEAR) && !wr_hit(wr_q, addr_q, OFF_DEACTIVATE))
      |=> pend_q == $past(pend_q))
      else $error("pending moved without sample tick");

   clockless_path_sel_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && |(active_q & clockless_path_sel_q & ~(lines.pin ^ ((mode_q & lvl_q) | (~mode_q & edge_q))))) |=> wake_q)
      else $error("clockless_path_sel level gave no wake");

   masked_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ce |=> (irq_q & ~$past(mask_q)) == LINE_RST)
      else $error("request on masked line");

   inact_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ce |=> (irq_q & ~$past(active_q)) == LINE_RST)
      else $error("request on inactive line");

   no_wake_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (ce && active_q == LINE_RST) |=> !wake_q)
      else $error("wake with no active line");

   mask_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_ph && haddr[11:0] == OFF_MASK_STATE) |=> hrdata == {1'b0, $past(mask_q)})
      else $error("mask state read wrong");

   pend_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_ph && haddr[11:0] == OFF_PEND_STATUS) |=> hrdata == {1'b0, $past(pend_q)})
      else $error("pending read wrong");

   act_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_ph && haddr[11:0] == OFF_ACTIVE_STATE) |=> hrdata == {1'b0, $past(active_q)})
      else $error("active state read wrong");

   cfg_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_ph && haddr[11:0] == OFF_TRIG_TYPE) |=> hrdata == {1'b0, $past(mode_q)})
      else $error("trigger type read wrong");

   test_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_ph && haddr[11:0] == OFF_TEST) |=> hrdata == $past(test_q))
      else $error("test word read wrong");

   wo_rd_a: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_ph && (haddr[11:0] == OFF_MASK_SET || haddr[11:0] == OFF_PEND_CLEAR || haddr[11:0] == OFF_DEACTIVATE))
      |=> hrdata == WORD_RST)
      else $error("write-only register read nonzero");

   freeze_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !ce |=> pend_q == $past(pend_q) && active_q == $past(active_q) && wake_q == $past(wake_q))
      else $error("state moved with enable low");

   irq_cov: cover property (@(posedge hclk) disable iff (!hresetn) |line_irq);
   nmi_cov: cover property (@(posedge hclk) disable iff (!hresetn) nmi_irq);
   masked_wake_cov: cover property (@(posedge hclk) disable iff (!hresetn) wake_q && (irq_q == LINE_RST));
   filt_cov: cover property (@(posedge hclk) disable iff (!hresetn) |(pend_q & filt_q & ~clockless_path_sel_q));
   clockless_path_sel_cov: cover property (@(posedge hclk) disable iff (!hresetn) wake_q && !samp_en);
endmodule
`default_nettype wire

// [core/epic_pkg.sv]
package epic_pkg;
   // ---------------------------------------------------------------
   // Line layout
   // ---------------------------------------------------------------
   localparam int NL = 31;
   localparam int NMI_BIT = 0;
   localparam logic [31:0] LINE_BITS = 32'h7FFFFFFF;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] OFF_MASK_SET = 12'h000;
   localparam logic [11:0] OFF_MASK_CLEAR = 12'h004;
   localparam logic [11:0] OFF_MASK_STATE = 12'h008;
   localparam logic [11:0] OFF_PEND_STATUS = 12'h00C;
   localparam logic [11:0] OFF_PEND_CLEAR = 12'h010;
   localparam logic [11:0] OFF_TRIG_TYPE = 12'h014;
   localparam logic [11:0] OFF_EDGE_POL = 12'h018;
   localparam logic [11:0] OFF_LEVEL_POL = 12'h01C;
   localparam logic [11:0] OFF_FILTER_SEL = 12'h020;
   localparam logic [11:0] OFF_TEST = 12'h024;
   localparam logic [11:0] OFF_CLOCKLESS_PATH_SEL_SEL = 12'h028;
   localparam logic [11:0] OFF_ACTIVATE = 12'h030;
   localparam logic [11:0] OFF_DEACTIVATE = 12'h034;
   localparam logic [11:0] OFF_ACTIVE_STATE = 12'h038;
   localparam logic [11:0] OFF_REVISION = 12'h3FC;
   // ---------------------------------------------------------------
   // Reset values and constants
   // ---------------------------------------------------------------
   localparam logic [NL-1:0] LINE_RST = 31'h00000000;
   localparam logic [31:0] WORD_RST = 32'h00000000;
   // Arbitrary revision value
   localparam logic [31:0] REVISION_VAL = 32'h00000100;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;
endpackage

// [core/epic_line_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface epic_line_if;
   import epic_pkg::*;
   logic [NL-1:0] mode;
   logic [NL-1:0] edg;
   logic [NL-1:0] lvl;
   logic [NL-1:0] filt;
   logic [NL-1:0] asyn;
   logic [NL-1:0] act;
   logic [NL-1:0] pin;
   logic [NL-1:0] trig;
   logic [NL-1:0] wake;
   modport ctl (output mode, edg, lvl, filt, asyn, act, pin, input trig, wake);
   modport det (input mode, edg, lvl, filt, asyn, act, pin, output trig, wake);
endinterface
`default_nettype wire

// [core/epic_line_det.sv]
`timescale 1ns/100ps
`default_nettype none
module epic_line_det
   import epic_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic samp_en,
   epic_line_if.det lines
);
   // ---------------------------------------------------------------
   // Sampling stages
   // ---------------------------------------------------------------
   logic samp;
   logic [NL-1:0] sync1_q;
   logic [NL-1:0] sync2_q;
   logic [NL-1:0] prev_q;
   logic [NL-1:0] hist0_q;
   logic [NL-1:0] hist1_q;
   logic [NL-1:0] cond;

   assign samp = ce & samp_en;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_q <= LINE_RST;
         sync2_q <= LINE_RST;
         prev_q <= LINE_RST;
      end else if (samp) begin
         // Two stages to tame metastability; short spikes may be missed
         sync1_q <= lines.pin;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hist0_q <= LINE_RST;
         hist1_q <= LINE_RST;
      end else if (samp) begin
         hist0_q <= cond;
         hist1_q <= hist0_q;
      end
   end

   // ---------------------------------------------------------------
   // Per-line trigger decision
   // ---------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < NL; i = i + 1) begin : g_line
         logic edge_hit;
         logic level_hit;
         logic maj;
         logic apol;
         logic acond;
         logic sel;
         assign edge_hit = lines.edg[i] ? (sync2_q[i] & ~prev_q[i]) : (~sync2_q[i] & prev_q[i]);
         assign level_hit = lines.lvl[i] ? sync2_q[i] : ~sync2_q[i];
         assign cond[i] = lines.mode[i] ? level_hit : edge_hit;
         assign maj = (cond[i] & hist0_q[i]) | (cond[i] & hist1_q[i]) | (hist0_q[i] & hist1_q[i]);
         // Edge selections read as levels on the clockless path
         assign apol = lines.mode[i] ? lines.lvl[i] : lines.edg[i];
         assign acond = apol ? lines.pin[i] : ~lines.pin[i];
         assign sel = lines.asyn[i] ? acond : (lines.filt[i] ? maj : cond[i]);
         assign lines.trig[i] = lines.act[i] & sel & samp;
         assign lines.wake[i] = lines.act[i] & (lines.trig[i] | (lines.asyn[i] & acond));
      end
   endgenerate
endmodule
`default_nettype wire

// [sim/epic_cpu_model.sv]
`timescale 1ns/100ps
`default_nettype none
module epic_cpu_model
   import epic_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clr,
   input wire logic nmi_irq,
   input wire logic [29:0] line_irq,
   input wire logic wake_out,
   output logic [31:0] seen_q
);
   // ---------------------------------------------------------------
   // Request log
   // ---------------------------------------------------------------
   // Sticky, so a short request is not lost between bus reads
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seen_q <= WORD_RST;
      end else if (clr) begin
         seen_q <= WORD_RST;
      end else begin
         seen_q <= seen_q | {wake_out, line_irq, nmi_irq};
      end
   end
endmodule
`default_nettype wire

// [sim/external_pin_interrupt_ctrl_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module external_pin_interrupt_ctrl_bench;
   import epic_pkg::*;
   logic hclk, hresetn, ce, samp_en, hsel, hwrite, clr, hreadyout, hresp, nmi_irq, wake_out;
   logic [31:0] haddr, hwdata, hrdata, seen;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [30:0] pins;
   logic [29:0] line_irq;
   wire logic [31:0] obs = {wake_out, line_irq, nmi_irq};
   int mismatches, checked;
   epic_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .samp_en(samp_en), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .nmi_pin(pins[0]), .ext_irq_pin(pins[30:1]), .nmi_irq(nmi_irq), .line_irq(line_irq),
      .wake_out(wake_out));
   epic_cpu_model i_cpu (.hclk(hclk), .hresetn(hresetn), .clr(clr), .nmi_irq(nmi_irq),
      .line_irq(line_irq), .wake_out(wake_out), .seen_q(seen));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic end_of_test();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         chk(32'h0, 32'h1);
         end_of_test();
      end
   endtask
   // Address phase held until hready, then data phase until hready
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= {20'h00000, a};
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(a, 1'b1, d, r);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      xfer(a, 1'b0, 32'h00000000, r);
      chk(r, exp);
      chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
   endtask
   task automatic wait_obs(input int b, input logic v);
      int n;
      n = 0;
      while (obs[b] !== v && n < 20) begin
         @(posedge hclk);
         n++;
      end
      chk({31'h0, obs[b]}, {31'h0, v});
      if (n >= 20) begin
         end_of_test();
      end
   endtask
   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   localparam logic [11:0] RW_OFF [5] = '{OFF_TRIG_TYPE, OFF_EDGE_POL, OFF_LEVEL_POL, OFF_FILTER_SEL, OFF_CLOCKLESS_PATH_SEL_SEL};
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   initial begin
      {hresetn, hsel, hwrite, clr, htrans, haddr, hwdata, pins} = '0;
      {ce, samp_en} = 2'h3;
      hsize = 3'h2;
      mismatches = 0;
      checked = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      for (int i = 0; i < 15; i++) begin
         rdc(12'(4 * i), WORD_RST);
      end
      rdc(OFF_REVISION, REVISION_VAL);
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         wr(RW_OFF[i], 32'hFFFFFFFF);
         rdc(RW_OFF[i], LINE_BITS);
         wr(RW_OFF[i], WORD_RST);
      end
      wr(OFF_TEST, 32'hA55AC33C);
      rdc(OFF_TEST, 32'hA55AC33C);
      wr(OFF_MASK_SET, 32'h8000000F);
      rdc(OFF_MASK_STATE, 32'h0000000F);
      wr(OFF_MASK_CLEAR, 32'h00000006);
      wr(OFF_MASK_STATE, 32'hFFFFFFFF);
      rdc(OFF_MASK_STATE, 32'h00000009);
      $display("test registers done");
      wr(OFF_TRIG_TYPE, 32'h00000089);
      wr(OFF_EDGE_POL, 32'h00000020);
      wr(OFF_LEVEL_POL, 32'h00000009);
      pins <= 31'h000000C0;
      wr(OFF_ACTIVATE, 32'h000000E9);
      rdc(OFF_ACTIVE_STATE, 32'h000000E9);
      rdc(OFF_PEND_STATUS, WORD_RST);
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
      pins <= 31'h00000029;
      repeat (3) @(posedge hclk);
      chk({31'h0, obs[3]}, 32'h0);
      wait_obs(3, 1'b1);
      wait_obs(0, 1'b1);
      repeat (4) @(posedge hclk);
      rdc(OFF_PEND_STATUS, 32'h000000E9);
      chk(seen & 32'h800000E9, 32'h80000009);
      pins <= 31'h000000C0;
      repeat (6) @(posedge hclk);
      rdc(OFF_PEND_STATUS, 32'h000000E9);
      wr(OFF_PEND_CLEAR, 32'h000000E9);
      rdc(OFF_PEND_STATUS, WORD_RST);
      wait_obs(3, 1'b0);
      wait_obs(31, 1'b0);
      ce <= 1'b0;
      clr <= 1'b1;
      pins <= 31'h000000E0;
      @(posedge hclk);
      clr <= 1'b0;
      repeat (6) @(posedge hclk);
      chk(seen, WORD_RST);
      ce <= 1'b1;
      repeat (6) @(posedge hclk);
      rdc(OFF_PEND_STATUS, 32'h00000020);
      wr(OFF_DEACTIVATE, 32'h00000020);
      rdc(OFF_PEND_STATUS, WORD_RST);
      rdc(OFF_ACTIVE_STATE, 32'h000000C9);
      $display("test lines done");
      wr(OFF_DEACTIVATE, LINE_BITS);
      rdc(OFF_ACTIVE_STATE, WORD_RST);
      pins <= 31'h00000000;
      wr(OFF_TRIG_TYPE, 32'h00000100);
      wr(OFF_LEVEL_POL, 32'h00000100);
      wr(OFF_FILTER_SEL, 32'h00000100);
      wr(OFF_MASK_SET, 32'h00000100);
      wr(OFF_ACTIVATE, 32'h00000100);
      @(posedge hclk);
      pins <= 31'h00000100;
      @(posedge hclk);
      pins <= 31'h00000000;
      repeat (8) @(posedge hclk);
      chk({31'h0, obs[8]}, 32'h0);
      pins <= 31'h00000100;
      wait_obs(8, 1'b1);
      $display("test filter done");
      wr(OFF_DEACTIVATE, LINE_BITS);
      pins <= 31'h00000000;
      wr(OFF_TRIG_TYPE, WORD_RST);
      wr(OFF_EDGE_POL, 32'h00000200);
      wr(OFF_FILTER_SEL, 32'h00000200);
      wr(OFF_CLOCKLESS_PATH_SEL_SEL, 32'h00000200);
      wr(OFF_MASK_SET, 32'h00000200);
      wr(OFF_ACTIVATE, 32'h00000200);
      wait_obs(31, 1'b0);
      samp_en <= 1'b0;
      pins <= 31'h00000200;
      wait_obs(31, 1'b1);
      rdc(OFF_PEND_STATUS, WORD_RST);
      samp_en <= 1'b1;
      wait_obs(9, 1'b1);
      wr(OFF_PEND_CLEAR, 32'h00000200);
      repeat (4) @(posedge hclk);
      rdc(OFF_PEND_STATUS, 32'h00000200);
      $display("test clockless_path_sel done");
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      rdc(OFF_ACTIVE_STATE, WORD_RST);
      rdc(OFF_PEND_STATUS, WORD_RST);
      rdc(OFF_MASK_STATE, WORD_RST);
      repeat (4) @(posedge hclk);
      chk(obs, WORD_RST);
      $display("test second reset done");
      end_of_test();
   end
endmodule
`default_nettype wire
